// File: core/sfr_regs.sv
// Register, FIFO, baud divider and interrupt core of the serial port
//
// Notes on behaviour
// RQ1: Fill counts at 13:8 receive, 5:0 transmit.
// RQ2: Count bits beyond depth read zero.
// RQ3: Low data lane width follows word length.
// RQ4: High data lane width follows word length.
// RQ5: Serial clock equals clk over 2*(divisor+1).
// RQ6: Software changes divisor only while disabled.
// RQ7: Frame, activity, underrun events gated by enables.
// RQ8: Six buffer flags each gated by enables.
// RQ9: Watermark fires when level equals fill count.
// RQ10: Watermark level bits beyond depth absent; the mask is exact only for power-of-two depths.
// RQ11: Underrun sends underrun word when enabled.
// RQ12: Low underrun lane width follows word length.
// RQ13: High underrun lane width follows word length.
// RQ14: Empty flag is count zero, full is ones; full here is count equals depth.
// RQ15: Unused lanes ignored, read zero; storage 32 bits.
`timescale 1ns/100ps
module sfr_regs #(
  parameter int unsigned FIFO_DEPTH = sfr_pkg::DEPTH_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic rx_push,
  input wire logic [31:0] rx_word,
  input wire logic tx_pop,
  output logic [31:0] tx_word,
  output logic tx_word_valid,
  output logic shift_clk_tick,
  input wire logic frame_error_flag,
  input wire logic activity_flag,
  input wire logic shifter_empty_flag,
  output logic port_enable,
  output logic [4:0] variable_word_length,
  output logic irq
);
  import sfr_pkg::*;

  localparam int unsigned AW = $clog2(FIFO_DEPTH);
  // Counts hold values 0..FIFO_DEPTH, so bits above depth stay zero
  localparam logic [5:0] DEPTH6 = 6'(FIFO_DEPTH);
  localparam logic [5:0] LVL_MASK = 6'(2 * FIFO_DEPTH - 1);
  // Level bits that cannot name a count of this depth are not stored when the depth is a power of two
  localparam logic [15:0] WMARK_KEEP = {1'b1, 1'b0, LVL_MASK, 1'b1, 1'b0, LVL_MASK};

  // Lane mask for a given word length code
  function automatic logic [31:0] lane_mask(input logic [4:0] wl);
    if (wl == 5'h00 || wl > WLEN_24) begin
      lane_mask = 32'hffffffff;
    end else if (wl > WLEN_16) begin
      lane_mask = 32'h00ffffff;
    end else if (wl > WLEN_8) begin
      lane_mask = 32'h0000ffff;
    end else begin
      lane_mask = 32'h000000ff;
    end
  endfunction

  // Ring pointer step; wraps at the depth, so the depth need not be a power of two
  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    if (p == AW'(FIFO_DEPTH - 1)) begin
      ptr_next = '0;
    end else begin
      ptr_next = p + 1'b1;
    end
  endfunction

  logic [31:0] data_stage;
  logic [15:0] underrun_fill_low;
  logic [15:0] underrun_fill_high;
  logic [12:0] baud_divisor;
  logic [15:0] event_enable_low;
  logic [15:0] watermark_mask_high;
  logic enhanced_mode;
  logic underrun_fill_enable;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [31:0] rx_mem [FIFO_DEPTH];
  logic [31:0] tx_mem [FIFO_DEPTH];
  logic [AW-1:0] rx_wp, rx_rp, tx_wp, tx_rp;
  logic [5:0] rx_fill_count;
  logic [5:0] tx_fill_count;
  logic [12:0] baud_cnt;
  logic tx_underrun_flag;
  logic rx_overflow_flag;
  logic [15:0] rd_mux;
  logic [5:0] rx_cnt_prev, tx_cnt_prev;

  wire logic [31:0] lanes = lane_mask(variable_word_length);
  wire logic wr_hit_low = reg_write && reg_addr == OFS_DATA_LOW;
  wire logic wr_hit_high = reg_write && reg_addr == OFS_DATA_HIGH;
  wire logic rd_hit_low = reg_read && reg_addr == OFS_DATA_LOW;
  wire logic wr_hit_baud = reg_write && reg_addr == OFS_BAUD_LOW;
  wire logic wr_hit_event = reg_write && reg_addr == OFS_EVENT_EN_LOW;
  wire logic wr_hit_wmark = reg_write && reg_addr == OFS_WMARK_HIGH;
  wire logic wr_hit_urun_low = reg_write && reg_addr == OFS_URUN_LOW;
  wire logic wr_hit_urun_high = reg_write && reg_addr == OFS_URUN_HIGH;
  wire logic wr_hit_control = reg_write && reg_addr == OFS_CONTROL;
  wire logic wr_hit_irq_en = reg_write && reg_addr == OFS_IRQ_ENABLE;
  wire logic wr_hit_clear = reg_write && reg_addr == OFS_IRQ_CLEAR;
  wire logic wide_word = lanes[16];
  // Writing the highest used lane commits a word; narrow words commit on the low lane
  wire logic tx_push_req = wide_word ? wr_hit_high : wr_hit_low;
  wire logic rx_pop_req = rd_hit_low;
  wire logic rx_full_flag = rx_fill_count == DEPTH6;
  wire logic rx_empty_flag = rx_fill_count == 6'h00;
  wire logic tx_full_flag = tx_fill_count == DEPTH6;
  wire logic tx_empty_flag = tx_fill_count == 6'h00;
  wire logic tx_push = tx_push_req && !tx_full_flag && port_enable;
  wire logic rx_pop = rx_pop_req && !rx_empty_flag;
  wire logic rx_accept = rx_push && !rx_full_flag && port_enable;
  wire logic tx_take = tx_pop && !tx_empty_flag && port_enable;
  wire logic tx_starve = tx_pop && tx_empty_flag && port_enable;
  wire logic [31:0] tx_next_word = {wide_word ? reg_wdata : data_stage[31:16],
    wide_word ? data_stage[15:0] : reg_wdata} & lanes; // [RQ15]
  wire logic [31:0] rx_head = rx_mem[rx_rp] & lanes; // [RQ3] [RQ4]
  wire logic [31:0] underrun_fill_word =
    {underrun_fill_high, underrun_fill_low} & lanes; // [RQ12] [RQ13]
  // Status inputs come from logic on this clock, so they need no synchroniser
  // Flags as seen by the event enables, laid out like the enable register
  wire logic [15:0] flag_vec = {3'h0, frame_error_flag, activity_flag, 2'h0, tx_underrun_flag,
    shifter_empty_flag, rx_overflow_flag, rx_empty_flag, 1'b0, tx_empty_flag, 1'b0,
    tx_full_flag, rx_full_flag};
  wire logic any_event = |(flag_vec & event_enable_low & EVENT_EN_MASK); // [RQ7] [RQ8]
  wire logic [5:0] rx_level = watermark_mask_high[WM_RX_LSB +: 6];
  wire logic [5:0] tx_level = watermark_mask_high[WM_TX_LSB +: 6];
  // Match only on a change of count, so a level held at its count fires once per arrival
  wire logic rx_wm_hit = watermark_mask_high[WM_RX_EN] && rx_level <= DEPTH6 &&
    rx_level == rx_fill_count && rx_fill_count != rx_cnt_prev; // [RQ9]
  wire logic tx_wm_hit = watermark_mask_high[WM_TX_EN] && tx_level <= DEPTH6 &&
    tx_level == tx_fill_count && tx_fill_count != tx_cnt_prev; // [RQ9]
  wire logic [2:0] irq_set = {tx_wm_hit, rx_wm_hit, any_event};
  wire logic [2:0] irq_clr = wr_hit_clear ? reg_wdata[2:0] : 3'h0;
  wire logic baud_wrap = baud_cnt == baud_divisor;

  // Read decode
  always_comb begin
    rd_mux = 16'h0000;
    if (reg_addr == OFS_FILL_COUNTS) begin
      rd_mux = enhanced_mode ? {2'h0, rx_fill_count, 2'h0, tx_fill_count} : 16'h0000; // [RQ1] [RQ2]
    end else if (reg_addr == OFS_DATA_LOW) begin
      rd_mux = rx_head[15:0];
    end else if (reg_addr == OFS_DATA_HIGH) begin
      rd_mux = rx_head[31:16];
    end else if (reg_addr == OFS_BAUD_LOW) begin
      rd_mux = {3'h0, baud_divisor};
    end else if (reg_addr == OFS_EVENT_EN_LOW) begin
      rd_mux = event_enable_low;
    end else if (reg_addr == OFS_WMARK_HIGH) begin
      rd_mux = watermark_mask_high;
    end else if (reg_addr == OFS_URUN_LOW) begin
      rd_mux = underrun_fill_word[15:0];
    end else if (reg_addr == OFS_URUN_HIGH) begin
      rd_mux = underrun_fill_word[31:16];
    end else if (reg_addr == OFS_CONTROL) begin
      rd_mux = {3'h0, variable_word_length, 5'h00, underrun_fill_enable, enhanced_mode,
        port_enable};
    end else if (reg_addr == OFS_IRQ_STATUS) begin
      rd_mux = {13'h0000, irq_status};
    end else if (reg_addr == OFS_IRQ_ENABLE) begin
      rd_mux = {13'h0000, irq_enable};
    end else if (reg_addr == OFS_FLAGS) begin
      rd_mux = flag_vec;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= REG_RESET;
    end else begin
      reg_rdata <= reg_read ? rd_mux : REG_RESET;
    end
  end

  // Software registers, one short process each; unused lanes of the data stage are never stored
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      data_stage <= 32'h00000000;
    end else if (wr_hit_low) begin
      data_stage[15:0] <= reg_wdata & lanes[15:0]; // [RQ15]
    end else if (wr_hit_high) begin
      data_stage[31:16] <= reg_wdata & lanes[31:16]; // [RQ15]
    end
  end

  // Live divisor; a change while enabled only disturbs the current period
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      baud_divisor <= BAUD_RESET;
    end else if (wr_hit_baud) begin
      baud_divisor <= reg_wdata[12:0]; // [RQ6]
    end
  end

  // Unused enable positions are not stored, so they read back zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      event_enable_low <= REG_RESET;
    end else if (wr_hit_event) begin
      event_enable_low <= reg_wdata & EVENT_EN_MASK; // [RQ7] [RQ8]
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      watermark_mask_high <= REG_RESET;
    end else if (wr_hit_wmark) begin
      watermark_mask_high <= reg_wdata & WMARK_KEEP; // [RQ10]
    end
  end

  // Underrun word kept whole; lanes are trimmed where it is used
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      underrun_fill_low <= REG_RESET;
      underrun_fill_high <= REG_RESET;
    end else if (wr_hit_urun_low) begin
      underrun_fill_low <= reg_wdata;
    end else if (wr_hit_urun_high) begin
      underrun_fill_high <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_enable <= 1'b0;
      enhanced_mode <= 1'b0;
      underrun_fill_enable <= 1'b0;
      variable_word_length <= WLEN_RESET;
    end else if (wr_hit_control) begin
      port_enable <= reg_wdata[CTL_ENABLE];
      enhanced_mode <= reg_wdata[CTL_ENHANCED];
      underrun_fill_enable <= reg_wdata[CTL_URUN_EN];
      variable_word_length <= reg_wdata[CTL_WLEN_LSB +: 5];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_enable <= 3'h0;
    end else if (wr_hit_irq_en) begin
      irq_enable <= reg_wdata[2:0] & IRQ_MASK;
    end
  end

  // FIFOs and fill counts
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_wp <= '0;
      rx_rp <= '0;
      tx_wp <= '0;
      tx_rp <= '0;
      rx_fill_count <= 6'h00;
      tx_fill_count <= 6'h00;
      rx_cnt_prev <= 6'h00;
      tx_cnt_prev <= 6'h00;
    end else begin
      rx_cnt_prev <= rx_fill_count;
      tx_cnt_prev <= tx_fill_count;
      if (rx_accept) begin
        rx_wp <= ptr_next(rx_wp);
      end
      if (rx_pop) begin
        rx_rp <= ptr_next(rx_rp);
      end
      if (tx_push) begin
        tx_wp <= ptr_next(tx_wp);
      end
      if (tx_take) begin
        tx_rp <= ptr_next(tx_rp);
      end
      // Counts run from zero up to the depth itself; full means count equals depth
      rx_fill_count <= rx_fill_count + 6'(rx_accept) - 6'(rx_pop); // [RQ1] [RQ14]
      tx_fill_count <= tx_fill_count + 6'(tx_push) - 6'(tx_take); // [RQ1] [RQ14]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rx_accept) begin
      rx_mem[rx_wp] <= rx_word; // [RQ15]
    end
    if (tx_push) begin
      tx_mem[tx_wp] <= tx_next_word;
    end
  end

  // Word handed to the shifter; underrun word substitutes when the FIFO starves
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_word <= 32'h00000000;
      tx_word_valid <= 1'b0;
    end else if (tx_take) begin
      tx_word <= tx_mem[tx_rp] & lanes;
      tx_word_valid <= 1'b1;
    end else if (tx_starve) begin
      tx_word <= underrun_fill_enable ? underrun_fill_word : 32'h00000000; // [RQ11]
      tx_word_valid <= underrun_fill_enable; // [RQ11]
    end else begin
      tx_word_valid <= 1'b0;
    end
  end

  // Error flags; set wins over clearing, disable clears underrun
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_underrun_flag <= 1'b0;
      rx_overflow_flag <= 1'b0;
    end else begin
      tx_underrun_flag <= tx_starve || (tx_underrun_flag && port_enable && !tx_push);
      rx_overflow_flag <= (rx_push && rx_full_flag && port_enable) ||
        (rx_overflow_flag && port_enable);
    end
  end

  // Baud divider: tick every divisor+1 cycles, toggling gives 2*(divisor+1)
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      baud_cnt <= 13'h0000;
      shift_clk_tick <= 1'b0;
    end else if (!port_enable) begin
      baud_cnt <= 13'h0000;
      shift_clk_tick <= 1'b0;
    end else begin
      baud_cnt <= baud_wrap ? 13'h0000 : baud_cnt + 13'h0001; // [RQ5]
      shift_clk_tick <= baud_wrap; // [RQ5]
    end
  end

  // Interrupt status and output
  // Output follows the next status, so a new event reaches the pin without an extra cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= irq_set | (irq_status & ~irq_clr);
      irq <= |((irq_set | (irq_status & ~irq_clr)) & irq_enable);
    end
  end
endmodule // sfr_regs

// File: core/sfr_pkg.sv
// Constants and register map of the serial port FIFO, interrupt and register block
package sfr_pkg;
  localparam int unsigned DEPTH_DEFAULT = 32;
  localparam logic [3:0] OFS_FILL_COUNTS = 4'h0;
  localparam logic [3:0] OFS_DATA_LOW = 4'h1;
  localparam logic [3:0] OFS_DATA_HIGH = 4'h2;
  localparam logic [3:0] OFS_BAUD_LOW = 4'h3;
  localparam logic [3:0] OFS_EVENT_EN_LOW = 4'h4;
  localparam logic [3:0] OFS_WMARK_HIGH = 4'h5;
  localparam logic [3:0] OFS_URUN_LOW = 4'h6;
  localparam logic [3:0] OFS_URUN_HIGH = 4'h7;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h9;
  localparam logic [3:0] OFS_IRQ_CLEAR = 4'ha;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'hb;
  localparam logic [3:0] OFS_FLAGS = 4'hc;
  // Control register fields
  localparam int unsigned CTL_ENABLE = 0;
  localparam int unsigned CTL_ENHANCED = 1;
  localparam int unsigned CTL_URUN_EN = 2;
  localparam int unsigned CTL_WLEN_LSB = 8;
  // Flag / event-enable bit positions
  localparam int unsigned EV_FRAME_ERR = 12;
  localparam int unsigned EV_ACTIVITY = 11;
  localparam int unsigned EV_UNDERRUN = 8;
  localparam int unsigned EV_SHIFT_EMPTY = 7;
  localparam int unsigned EV_RX_OVF = 6;
  localparam int unsigned EV_RX_EMPTY = 5;
  localparam int unsigned EV_TX_EMPTY = 3;
  localparam int unsigned EV_TX_FULL = 1;
  localparam int unsigned EV_RX_FULL = 0;
  localparam logic [15:0] EVENT_EN_MASK = 16'h19eb;
  // Watermark register fields
  localparam int unsigned WM_RX_EN = 15;
  localparam int unsigned WM_RX_LSB = 8;
  localparam int unsigned WM_TX_EN = 7;
  localparam int unsigned WM_TX_LSB = 0;
  // Sticky interrupt status bits
  localparam int unsigned IRQ_EVENT = 0;
  localparam int unsigned IRQ_RX_WMARK = 1;
  localparam int unsigned IRQ_TX_WMARK = 2;
  localparam logic [2:0] IRQ_MASK = 3'h7;
  localparam logic [12:0] BAUD_RESET = 13'h0000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [4:0] WLEN_RESET = 5'h1f;
  localparam logic [5:0] COUNT_ALL_ONES = 6'h3f;
  // Word-length codes: value = bits minus one; 0 means 32 bits
  localparam logic [4:0] WLEN_8 = 5'h07;
  localparam logic [4:0] WLEN_16 = 5'h0f;
  localparam logic [4:0] WLEN_24 = 5'h17;
endpackage

// File: dv/sfr_regs_properties.sv
// Assertion checker for the serial port register block
`timescale 1ns/100ps
module sfr_regs_properties
  import sfr_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = DEPTH_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic tx_pop,
  input wire logic tx_word_valid,
  input wire logic shift_clk_tick,
  input wire logic port_enable,
  input wire logic irq
);
  // Count bits above the configured depth must read zero
  localparam logic [15:0] CNT_ZERO = 16'hc0c0 | (FIFO_DEPTH < 32 ? 16'h2020 : 16'h0000)
    | (FIFO_DEPTH < 16 ? 16'h1010 : 16'h0000) | (FIFO_DEPTH < 8 ? 16'h0808 : 16'h0000);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [12:0] div_q;
  logic [12:0] gap_q;
  logic armed_q;
  wire baud_wr = reg_write && reg_addr == OFS_BAUD_LOW;
  // Spacing is judged only between two ticks of one enabled stretch
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_q <= 13'h0000;
      gap_q <= 13'h0000;
      armed_q <= 1'b0;
    end else begin
      if (baud_wr) begin
        div_q <= reg_wdata[12:0];
      end
      gap_q <= shift_clk_tick ? 13'h0000 : gap_q + 13'h0001;
      armed_q <= port_enable && !baud_wr && (armed_q || shift_clk_tick);
    end
  end
  sequence s_rd(logic [3:0] a);
    reg_read && reg_addr == a;
  endsequence
  sequence s_irq_off;
    reg_write && reg_addr == OFS_IRQ_ENABLE && reg_wdata[2:0] == 3'h0 ##1
      !(reg_write && reg_addr == OFS_IRQ_ENABLE);
  endsequence
  AST_RD_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside answer");
  AST_CNT_ZERO: assert property (s_rd(OFS_FILL_COUNTS) |=> !(reg_rdata & CNT_ZERO))
    else $error("fill count bit beyond depth");
  AST_BAUD_RB: assert property (s_rd(OFS_BAUD_LOW) |=> reg_rdata[15:13] == 3'h0)
    else $error("divisor upper bits not zero");
  AST_EVEN_RB: assert property (s_rd(OFS_EVENT_EN_LOW) |=> !(reg_rdata & ~EVENT_EN_MASK))
    else $error("unused event enable bit set");
  AST_WM_RB: assert property (s_rd(OFS_WMARK_HIGH) |=> !(reg_rdata & 16'h4040))
    else $error("unused watermark bit set");
  AST_UNMAPPED: assert property (reg_read && reg_addr > OFS_FLAGS |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_TICK_PERIOD: assert property (shift_clk_tick && armed_q |-> gap_q == div_q)
    else $error("tick spacing differs from divisor");
  AST_TICK_OFF: assert property (!port_enable ##1 !port_enable |-> !shift_clk_tick)
    else $error("tick while disabled");
  AST_VALID_POP: assert property (tx_word_valid |-> $past(tx_pop))
    else $error("transmit word without pop");
  AST_IRQ_OFF: assert property (s_irq_off |=> !irq)
    else $error("interrupt high with all enables off");
endmodule // sfr_regs_properties

bind sfr_regs sfr_regs_properties #(.FIFO_DEPTH(FIFO_DEPTH)) sfr_regs_properties_i (
  .clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .tx_pop, .tx_word_valid, .shift_clk_tick, .port_enable, .irq
);

// File: dv/sfr_shifter_model.sv
// Far-side shifter model: moves words only on serial clock ticks
`timescale 1ns/100ps
module sfr_shifter_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic shift_clk_tick,
  input wire logic push_req,
  input wire logic [31:0] push_data,
  input wire logic pop_req,
  output logic rx_push,
  output logic [31:0] rx_word,
  output logic tx_pop
);
  logic push_pend;
  logic pop_pend;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      push_pend <= 1'b0;
      pop_pend <= 1'b0;
      rx_push <= 1'b0;
      tx_pop <= 1'b0;
      rx_word <= 32'h00000000;
    end else begin
      push_pend <= push_req || (push_pend && !shift_clk_tick);
      pop_pend <= pop_req || (pop_pend && !shift_clk_tick);
      rx_push <= push_pend && shift_clk_tick;
      tx_pop <= pop_pend && shift_clk_tick;
      // Outside a push the word toggles so stale data is never mistaken for valid
      rx_word <= (push_pend && shift_clk_tick) ? push_data : ~rx_word;
    end
  end
endmodule // sfr_shifter_model

// File: dv/tb_top.sv
// Self-checking testbench for the serial port register block
`timescale 1ns/100ps
module tb_top;
  import sfr_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic frame_error_flag = 1'b0;
  logic activity_flag = 1'b0;
  logic shifter_empty_flag = 1'b0;
  logic push_req = 1'b0;
  logic pop_req = 1'b0;
  logic [31:0] push_data = 32'h00000000;
  logic [15:0] reg_rdata;
  logic rx_push;
  logic [31:0] rx_word;
  logic tx_pop;
  logic [31:0] tx_word;
  logic tx_word_valid;
  logic shift_clk_tick;
  logic port_enable;
  logic [4:0] variable_word_length;
  logic irq;
  logic [3:0] ra [4] = '{OFS_BAUD_LOW, OFS_EVENT_EN_LOW, OFS_WMARK_HIGH, 4'hd};
  logic [15:0] rm [4] = '{16'h1fff, EVENT_EN_MASK, 16'hbfbf, 16'h0000};
  logic [4:0] wl [4] = '{5'h07, 5'h08, 5'h17, 5'h18};
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed;
  sfr_regs #(.FIFO_DEPTH(DEPTH_DEFAULT)) sfr_regs_i (.clk_sys, .reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .rx_push, .rx_word, .tx_pop, .tx_word, .tx_word_valid,
    .shift_clk_tick, .frame_error_flag, .activity_flag, .shifter_empty_flag,
    .port_enable, .variable_word_length, .irq);
  sfr_shifter_model sfr_shifter_model_i (.clk_sys, .reset, .shift_clk_tick, .push_req,
    .push_data, .pop_req, .rx_push, .rx_word, .tx_pop);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Runs are short; a stuck handshake ends here instead of hanging
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    tick(1);
    reg_read <= 1'b0;
    d = reg_rdata;
  endtask
  task automatic shift(input logic is_push, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    push_req <= is_push;
    pop_req <= !is_push;
    push_data <= d;
    do begin
      tick(1);
      push_req <= 1'b0;
      pop_req <= 1'b0;
      n++;
    end while (rx_push !== 1'b1 && tx_pop !== 1'b1 && n < 300);
    tick(1);
  endtask
  function automatic logic [31:0] lane(input logic [4:0] c);
    if (c == 5'h00 || c > 5'h17) return 32'hffffffff;
    if (c > 5'h0f) return 32'h00ffffff;
    return (c > 5'h07) ? 32'h0000ffff : 32'h000000ff;
  endfunction
  initial begin
    logic [15:0] q;
    logic [15:0] hi;
    logic [31:0] w;
    logic [31:0] u;
    seed = 54;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    chk(variable_word_length, WLEN_RESET);
    for (int i = 0; i < 12; i++) begin
      w = $random(seed);
      rd(ra[i % 4], q);
      if (i < 4) chk(q, 16'h0000);
      wr(ra[i % 4], w[15:0]);
      rd(ra[i % 4], q);
      chk(q, w[15:0] & rm[i % 4]);
    end
    wr(OFS_WMARK_HIGH, 16'h0000);
    wr(OFS_EVENT_EN_LOW, 16'h0000);
    wr(OFS_BAUD_LOW, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      w = $random(seed);
      u = $random(seed);
      wr(OFS_CONTROL, 16'h0000);
      wr(OFS_CONTROL, {3'h0, wl[i], 8'h07});
      wr(OFS_URUN_LOW, u[15:0]);
      wr(OFS_URUN_HIGH, u[31:16]);
      wr(OFS_DATA_LOW, w[15:0]);
      if (wl[i] > 5'h0f) wr(OFS_DATA_HIGH, w[31:16]);
      rd(OFS_FILL_COUNTS, q);
      chk(q, 16'h0001);
      shift(1'b0, 32'h0);
      chk({tx_word_valid, tx_word}, {1'b1, w & lane(wl[i])});
      shift(1'b0, 32'h0);
      chk({tx_word_valid, tx_word}, {1'b1, u & lane(wl[i])});
    end
    wr(OFS_CONTROL, 16'h0000);
    wr(OFS_CONTROL, 16'h1f03);
    shift(1'b0, 32'h0);
    chk(tx_word_valid, 1'b0);
    w = $random(seed);
    shift(1'b1, w);
    rd(OFS_FILL_COUNTS, q);
    chk(q, 16'h0100);
    rd(OFS_FLAGS, q);
    chk(q[EV_RX_EMPTY], 1'b0);
    rd(OFS_DATA_HIGH, hi);
    rd(OFS_DATA_LOW, q);
    chk({hi, q}, w);
    rd(OFS_FLAGS, q);
    chk(q[EV_RX_EMPTY], 1'b1);
    wr(OFS_IRQ_ENABLE, 16'h0007);
    wr(OFS_EVENT_EN_LOW, 16'h1000);
    wr(OFS_IRQ_CLEAR, 16'h0007);
    tick(2);
    chk(irq, 1'b0);
    frame_error_flag <= 1'b1;
    tick(3);
    chk(irq, 1'b1);
    frame_error_flag <= 1'b0;
    // Raise the flag whose enable is off first, then the one whose enable is on
    for (int i = 0; i < 2; i++) begin
      wr(OFS_EVENT_EN_LOW, (i == 0) ? 16'h0800 : 16'h0080);
      wr(OFS_IRQ_CLEAR, 16'h0007);
      {activity_flag, shifter_empty_flag} <= (i == 0) ? 2'b01 : 2'b10;
      tick(3);
      chk(irq, 1'b0);
      {activity_flag, shifter_empty_flag} <= (i == 0) ? 2'b10 : 2'b01;
      tick(3);
      chk(irq, 1'b1);
      {activity_flag, shifter_empty_flag} <= 2'b00;
    end
    wr(OFS_EVENT_EN_LOW, 16'h0008);
    wr(OFS_IRQ_CLEAR, 16'h0007);
    rd(OFS_IRQ_STATUS, q);
    chk(q, 16'h0001);
    wr(OFS_IRQ_ENABLE, 16'h0000);
    tick(2);
    chk(irq, 1'b0);
    wr(OFS_EVENT_EN_LOW, 16'h0000);
    wr(OFS_WMARK_HIGH, 16'h8182);
    wr(OFS_IRQ_CLEAR, 16'h0007);
    wr(OFS_IRQ_ENABLE, 16'h0006);
    for (int i = 0; i < 2; i++) begin
      w = $random(seed);
      wr(OFS_DATA_LOW, w[15:0]);
      wr(OFS_DATA_HIGH, w[31:16]);
    end
    rd(OFS_IRQ_STATUS, q);
    chk(q, 16'h0004);
    chk(irq, 1'b1);
    shift(1'b1, w);
    rd(OFS_IRQ_STATUS, q);
    chk(q, 16'h0006);
    end_of_test();
  end
endmodule // tb_top
